// >>> status_arith_core.sv
// Contract
// RL1 - After reset the status word has its interrupt mask flag at one.
// RL2 - Software sets the index mode and base-ten flags itself after reset.
// RL3 - A written interrupt request value shows only after one more instruction ends.
// RL4 - With the base-ten flag at one, add and subtract work in decimal.
// RL5 - Software runs another instruction after a decimal op before carry or base-ten ops.
// RL6 - In decimal mode only the carry from add or subtract is meaningful.
// RL7 - Multiply and divide ignore the index mode and base-ten flags.
// RL8 - Multiply and divide leave the whole status word unchanged.
// RL9 - Each op lasts its cycle count of an internal clock at half the input rate.
// RL10 - On leaving reset the program counter loads the two-byte start vector.
module status_arith_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] reset_vec_hi,
	input wire logic [7:0] reset_vec_lo,
	output logic cpu_clk,
	output logic busy
);
	import core_pkg::*;

	typedef enum logic {ST_IDLE, ST_RUN} state_type;

	// ****************
	// Storage
	// ****************
	state_type state_ff, nxt_state;
	op_type op_ff;
	logic [6:0] cnt_ff, nxt_cnt;
	logic [7:0] opa_ff, opb_ff, psw_ff, nxt_psw;
	logic [7:0] res_lo_ff, res_hi_ff;
	logic [7:0] irq_wr_ff, irq_vis_ff;
	logic [15:0] pc_ff;
	logic vec_done_ff;
	logic phi_ff;
	logic pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;

	arith_if ai ();

	arith_unit u_arith (
		.ai(ai)
	);

	// ****************
	// Bus decode
	// ****************
	logic setup_wait, stall, commit, wr, hit;
	logic hit_opa, hit_opb, hit_cmd, hit_psw, hit_irq;
	logic start, done, busy_now;
	logic [31:0] rd_mux;
	logic [6:0] cyc_sel;
	op_type cmd_op;

	assign busy_now = (state_ff == ST_RUN);
	assign stall = pwrite && busy_now;
	assign setup_wait = psel && penable && !pready_ff && !stall;
	assign commit = psel && penable && pready_ff;
	assign wr = commit && pwrite && hit;
	assign hit_opa = (paddr == ADDR_OPA);
	assign hit_opb = (paddr == ADDR_OPB);
	assign hit_cmd = (paddr == ADDR_CMD);
	assign hit_psw = (paddr == ADDR_PSW);
	assign hit_irq = (paddr == ADDR_IRQ);
	assign hit = hit_opa || hit_opb || hit_cmd || hit_psw || hit_irq
		|| (paddr == ADDR_RES) || (paddr == ADDR_PC) || (paddr == ADDR_STAT);
	assign cmd_op = op_type'(pwdata[3:0]);
	assign start = wr && hit_cmd && vec_done_ff;
	assign done = busy_now && (cnt_ff == CNT_ONE);

	assign rd_mux = hit_opa ? {24'h00_0000, opa_ff} :
		hit_opb ? {24'h00_0000, opb_ff} :
		hit_cmd ? {28'h000_0000, op_ff} :
		hit_psw ? {24'h00_0000, psw_ff} :
		(paddr == ADDR_RES) ? {16'h0000, res_hi_ff, res_lo_ff} :
		hit_irq ? {24'h00_0000, irq_vis_ff} :
		(paddr == ADDR_PC) ? {16'h0000, pc_ff} :
		(paddr == ADDR_STAT) ? {30'h0000_0000, vec_done_ff, busy_now} :
		32'h0000_0000;

	// ****************
	// Sequencing
	// ****************
	assign cyc_sel = (cmd_op == OP_MUL) ? CYC_MUL :
		(cmd_op == OP_DIV) ? CYC_DIV :
		(cmd_op == OP_ADC || cmd_op == OP_SBC) ? CYC_ALU : CYC_FLAG;

	// Op length counted in input clocks, two per internal cycle
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		if (start) begin
			nxt_state = ST_RUN;
			nxt_cnt = 7'(cyc_sel * PHI_DIV); // RL9
		end else if (done) begin
			nxt_state = ST_IDLE;
			nxt_cnt = 7'h00;
		end else if (busy_now) begin
			nxt_cnt = cnt_ff - CNT_ONE;
		end
	end

	assign ai.a = opa_ff;
	assign ai.b = opb_ff;
	assign ai.cin = psw_ff[PSW_C];
	assign ai.op = op_ff;
	// Fixed binary behaviour for multiply and divide
	assign ai.dec = psw_ff[PSW_D] && (op_ff == OP_ADC || op_ff == OP_SBC); // RL7

	// ****************
	// Status word update
	// ****************
	always_comb begin
		nxt_psw = psw_ff;
		if (wr && hit_psw) begin
			nxt_psw = pwdata[7:0];
		end else if (done) begin
			case (op_ff)
				OP_ADC, OP_SBC: begin
					nxt_psw[PSW_C] = ai.cout;
					// Sign, overflow and zero not updated in decimal mode
					if (!psw_ff[PSW_D]) begin // RL6
						nxt_psw[PSW_N] = ai.lo[7];
						nxt_psw[PSW_V] = ai.vout;
						nxt_psw[PSW_Z] = (ai.lo == BYTE_ZERO);
					end
				end
				OP_SEC: nxt_psw[PSW_C] = 1'b1;
				OP_CLC: nxt_psw[PSW_C] = 1'b0;
				OP_SED: nxt_psw[PSW_D] = 1'b1;
				OP_CLD: nxt_psw[PSW_D] = 1'b0;
				default: nxt_psw = psw_ff; // RL8
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 7'h00;
			op_ff <= OP_NOP;
			psw_ff <= PSW_RESET; // RL1
			phi_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			psw_ff <= nxt_psw;
			phi_ff <= !phi_ff; // RL9
			if (start) begin
				op_ff <= cmd_op;
			end
		end
	end

	// ****************
	// Data registers
	// ****************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opa_ff <= BYTE_ZERO;
			opb_ff <= BYTE_ZERO;
			res_lo_ff <= BYTE_ZERO;
			res_hi_ff <= BYTE_ZERO;
		end else begin
			if (wr && hit_opa) begin
				opa_ff <= pwdata[7:0];
			end
			if (wr && hit_opb) begin
				opb_ff <= pwdata[7:0];
			end
			if (done && op_ff != OP_SEC && op_ff != OP_CLC
				&& op_ff != OP_SED && op_ff != OP_CLD) begin
				res_lo_ff <= ai.lo;
				res_hi_ff <= ai.hi;
			end
		end
	end

	// Request bits reach the readable copy at the end of the next op
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_wr_ff <= BYTE_ZERO;
			irq_vis_ff <= BYTE_ZERO;
		end else begin
			if (wr && hit_irq) begin
				irq_wr_ff <= pwdata[7:0];
			end
			if (done) begin
				irq_vis_ff <= irq_wr_ff; // RL3
			end
		end
	end

	// Vector taken on the first edge after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_ff <= 16'h0000;
			vec_done_ff <= 1'b0;
		end else if (!vec_done_ff) begin
			pc_ff <= {reset_vec_hi, reset_vec_lo}; // RL10
			vec_done_ff <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= setup_wait;
			pslverr_ff <= setup_wait && !hit;
			if (setup_wait) begin
				prdata_ff <= rd_mux;
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign cpu_clk = phi_ff;
	assign busy = busy_now;

	// ****************
	// Checks
	// ****************
	localparam int MUL_TICKS = 30;
	localparam int DIV_TICKS = 32;

	sequence s_alu_run;
		busy_now [*4] ##1 !busy_now;
	endsequence

	sequence s_mul_done;
		done && (op_ff == OP_MUL || op_ff == OP_DIV);
	endsequence

	sequence s_mul_start;
		start && cmd_op == OP_MUL;
	endsequence

	sequence s_div_start;
		start && cmd_op == OP_DIV;
	endsequence

	chk_reset_mask: assert property (@(posedge pclk) disable iff (!presetn) // RL1
		!vec_done_ff |-> psw_ff[PSW_I])
		else $error("mask flag not set after reset");

	chk_irq_hidden: assert property (@(posedge pclk) disable iff (!presetn) // RL3
		(wr && hit_irq && !done) |=> (irq_vis_ff == $past(irq_vis_ff)))
		else $error("request bit visible too early");

	chk_irq_shows: assert property (@(posedge pclk) disable iff (!presetn) // RL3
		done |=> (irq_vis_ff == $past(irq_wr_ff)))
		else $error("request bit not shown after op");

	chk_alu_length: assert property (@(posedge pclk) disable iff (!presetn) // RL9
		(start && (cmd_op == OP_ADC || cmd_op == OP_SBC)) |=> s_alu_run)
		else $error("add or subtract length wrong");

	chk_phi_half: assert property (@(posedge pclk) disable iff (!presetn) // RL9
		$past(presetn) |-> (phi_ff != $past(phi_ff)))
		else $error("internal clock not at half rate");

	chk_muldiv_psw: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		(s_mul_done and !(wr && hit_psw)) |=> $stable(psw_ff))
		else $error("multiply or divide changed status");

	chk_mul_value: assert property (@(posedge pclk) disable iff (!presetn) // RL7
		(done && op_ff == OP_MUL) |=>
			({res_hi_ff, res_lo_ff} == 16'($past(opa_ff)) * 16'($past(opb_ff))))
		else $error("product wrong");

	chk_dec_nvz: assert property (@(posedge pclk) disable iff (!presetn) // RL6
		(done && psw_ff[PSW_D] && (op_ff == OP_ADC || op_ff == OP_SBC) && !(wr && hit_psw))
		|=> ($stable(psw_ff[PSW_N]) && $stable(psw_ff[PSW_V]) && $stable(psw_ff[PSW_Z])))
		else $error("decimal op touched sign flags");

	chk_dec_digits: assert property (@(posedge pclk) disable iff (!presetn) // RL4
		(done && ai.dec && opa_ff[3:0] <= 4'h9 && opb_ff[3:0] <= 4'h9
			&& opa_ff[7:4] <= 4'h9 && opb_ff[7:4] <= 4'h9)
		|=> (res_lo_ff[3:0] <= 4'h9 && res_lo_ff[7:4] <= 4'h9))
		else $error("decimal result not decimal");

	chk_vector_load: assert property (@(posedge pclk) disable iff (!presetn) // RL10
		$rose(vec_done_ff) |-> (pc_ff == {$past(reset_vec_hi), $past(reset_vec_lo)}))
		else $error("start vector not loaded");

	chk_mul_length: assert property (@(posedge pclk) disable iff (!presetn) // RL9
		s_mul_start |-> ##MUL_TICKS (done && op_ff == OP_MUL))
		else $error("multiply length wrong");

	chk_div_length: assert property (@(posedge pclk) disable iff (!presetn) // RL9
		s_div_start |-> ##DIV_TICKS (done && op_ff == OP_DIV))
		else $error("divide length wrong");

	chk_div_value: assert property (@(posedge pclk) disable iff (!presetn) // RL7
		(done && op_ff == OP_DIV && opb_ff != BYTE_ZERO) |=>
			(res_lo_ff == $past(opa_ff) / $past(opb_ff)
			&& res_hi_ff == $past(opa_ff) % $past(opb_ff)))
		else $error("quotient or remainder wrong");
endmodule

// >>> core_pkg.sv
package core_pkg;
	// ****************
	// Register map
	// ****************
	localparam logic [7:0] ADDR_OPA = 8'h00;
	localparam logic [7:0] ADDR_OPB = 8'h04;
	localparam logic [7:0] ADDR_CMD = 8'h08;
	localparam logic [7:0] ADDR_PSW = 8'h0C;
	localparam logic [7:0] ADDR_RES = 8'h10;
	localparam logic [7:0] ADDR_IRQ = 8'h14;
	localparam logic [7:0] ADDR_PC = 8'h18;
	localparam logic [7:0] ADDR_STAT = 8'h1C;

	// ****************
	// Status word layout
	// ****************
	localparam int PSW_C = 0;
	localparam int PSW_Z = 1;
	localparam int PSW_I = 2;
	localparam int PSW_D = 3;
	localparam int PSW_T = 5;
	localparam int PSW_V = 6;
	localparam int PSW_N = 7;
	localparam logic [7:0] PSW_RESET = 8'h04;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ****************
	// Operations and timing
	// ****************
	typedef enum logic [3:0] {
		OP_ADC, OP_SBC, OP_MUL, OP_DIV, OP_SEC, OP_CLC, OP_SED, OP_CLD, OP_NOP
	} op_type;

	localparam logic [6:0] CYC_ALU = 7'h02;
	localparam logic [6:0] CYC_MUL = 7'h0F;
	localparam logic [6:0] CYC_DIV = 7'h10;
	localparam logic [6:0] CYC_FLAG = 7'h02;
	localparam logic [6:0] PHI_DIV = 7'h02;
	localparam logic [6:0] CNT_ONE = 7'h01;

	localparam logic [4:0] BCD_MAX = 5'h09;
	localparam logic [4:0] BCD_ADJ = 5'h06;
endpackage

// >>> arith_if.sv
interface arith_if;
	import core_pkg::*;
	logic [7:0] a;
	logic [7:0] b;
	logic cin;
	logic dec;
	op_type op;
	logic [7:0] lo;
	logic [7:0] hi;
	logic cout;
	logic vout;

	modport core (output a, output b, output cin, output dec, output op,
		input lo, input hi, input cout, input vout);
	modport unit (input a, input b, input cin, input dec, input op,
		output lo, output hi, output cout, output vout);
endinterface

// >>> arith_unit.sv
module arith_unit (
	arith_if.unit ai
);
	import core_pkg::*;

	logic [8:0] bin_sum;
	logic [4:0] dlo;
	logic [4:0] dhi;
	logic lo_c;
	logic hi_c;
	logic [15:0] prod;

	assign prod = 16'(ai.a) * 16'(ai.b);

	always_comb begin
		bin_sum = 9'h000;
		dlo = 5'h00;
		dhi = 5'h00;
		lo_c = 1'b0;
		hi_c = 1'b0;
		ai.lo = BYTE_ZERO;
		ai.hi = BYTE_ZERO;
		ai.cout = 1'b0;
		ai.vout = 1'b0;
		case (ai.op)
			OP_ADC, OP_SBC: begin
				if (ai.op == OP_ADC) begin
					bin_sum = {1'b0, ai.a} + {1'b0, ai.b} + 9'(ai.cin);
					ai.vout = (ai.a[7] == ai.b[7]) && (bin_sum[7] != ai.a[7]);
				end else begin
					bin_sum = {1'b0, ai.a} + {1'b0, ~ai.b} + 9'(ai.cin);
					ai.vout = (ai.a[7] != ai.b[7]) && (bin_sum[7] != ai.a[7]);
				end
				ai.lo = bin_sum[7:0];
				ai.cout = bin_sum[8];
				// Digit-wise correction in base-ten mode
				if (ai.dec && ai.op == OP_ADC) begin // RL4
					dlo = {1'b0, ai.a[3:0]} + {1'b0, ai.b[3:0]} + 5'(ai.cin);
					lo_c = dlo > BCD_MAX;
					if (lo_c) begin
						dlo = dlo + BCD_ADJ;
					end
					dhi = {1'b0, ai.a[7:4]} + {1'b0, ai.b[7:4]} + 5'(lo_c);
					hi_c = dhi > BCD_MAX;
					if (hi_c) begin
						dhi = dhi + BCD_ADJ;
					end
					ai.lo = {dhi[3:0], dlo[3:0]};
					ai.cout = hi_c;
				end else if (ai.dec) begin // RL4
					dlo = {1'b0, ai.a[3:0]} - {1'b0, ai.b[3:0]} - 5'(!ai.cin);
					lo_c = dlo[4];
					if (lo_c) begin
						dlo = dlo - BCD_ADJ;
					end
					dhi = {1'b0, ai.a[7:4]} - {1'b0, ai.b[7:4]} - 5'(lo_c);
					hi_c = dhi[4];
					if (hi_c) begin
						dhi = dhi - BCD_ADJ;
					end
					ai.lo = {dhi[3:0], dlo[3:0]};
					ai.cout = !hi_c;
				end
			end
			OP_MUL: begin
				ai.lo = prod[7:0];
				ai.hi = prod[15:8];
			end
			OP_DIV: begin
				// Divide by zero gives all ones and keeps the dividend
				if (ai.b == BYTE_ZERO) begin
					ai.lo = ~BYTE_ZERO;
					ai.hi = ai.a;
				end else begin
					ai.lo = ai.a / ai.b;
					ai.hi = ai.a % ai.b;
				end
			end
			default: begin
				ai.lo = BYTE_ZERO;
			end
		endcase
	end
endmodule

// >>> status_arith_core_tb.sv
module status_arith_core_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import core_pkg::*;

	// ****************
	// Stimulus table
	// ****************
	typedef struct {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] psw;
		op_type op;
		logic [15:0] res;
		logic [15:0] rm;
		logic [7:0] pe;
		logic [7:0] pm;
		int cyc;
	} row_type;

	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	localparam int LIMIT = 5000;

	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] vec_hi;
	logic [7:0] vec_lo;
	logic cpu_clk;
	logic busy;
	logic [31:0] rdat;
	logic rerr;
	logic ph;
	int fail_count;
	int n_tests;
	int cyc_cnt;
	int n;

	// Binary add rows come first, then decimal rows; flag ops follow only after other ops
	row_type rows [15] = '{
		'{8'h12, 8'h34, 8'h00, OP_ADC, 16'h0046, 16'h00FF, 8'h00, 8'hFF, 4},
		'{8'h80, 8'h80, 8'h00, OP_ADC, 16'h0000, 16'h00FF, 8'h43, 8'hFF, 4},
		'{8'h45, 8'h38, 8'h08, OP_ADC, 16'h0083, 16'h00FF, 8'h08, 8'h09, 4},
		'{8'h99, 8'h01, 8'h08, OP_ADC, 16'h0000, 16'h00FF, 8'h09, 8'h09, 4},
		'{8'h50, 8'h25, 8'h09, OP_SBC, 16'h0025, 16'h00FF, 8'h09, 8'h09, 4},
		'{8'h10, 8'h20, 8'h09, OP_SBC, 16'h0090, 16'h00FF, 8'h08, 8'h09, 4},
		'{8'h50, 8'h10, 8'h01, OP_SBC, 16'h0040, 16'h00FF, 8'h01, 8'hFF, 4},
		'{8'h12, 8'h34, 8'hEF, OP_MUL, 16'h03A8, 16'hFFFF, 8'hEF, 8'hFF, 30},
		'{8'h64, 8'h07, 8'h28, OP_DIV, 16'h020E, 16'hFFFF, 8'h28, 8'hFF, 32},
		'{8'h55, 8'h00, 8'h00, OP_DIV, 16'h55FF, 16'hFFFF, 8'h00, 8'hFF, 32},
		'{8'h00, 8'h00, 8'h00, OP_SEC, 16'h55FF, 16'hFFFF, 8'h01, 8'hFF, 4},
		'{8'h00, 8'h00, 8'h01, OP_CLC, 16'h55FF, 16'hFFFF, 8'h00, 8'hFF, 4},
		'{8'h00, 8'h00, 8'h00, OP_SED, 16'h55FF, 16'hFFFF, 8'h08, 8'hFF, 4},
		'{8'h00, 8'h00, 8'h08, OP_CLD, 16'h55FF, 16'hFFFF, 8'h00, 8'hFF, 4},
		'{8'h00, 8'h00, 8'h04, OP_NOP, 16'h0000, 16'hFFFF, 8'h04, 8'hFF, 4}
	};

	status_arith_core dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.reset_vec_hi(vec_hi),
		.reset_vec_lo(vec_lo),
		.cpu_clk(cpu_clk),
		.busy(busy)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ****************
	// Helpers
	// ****************
	task automatic end_of_test();
		if (fail_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc_cnt++;
		if (cyc_cnt == LIMIT) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
		n_tests++;
		if ((got & mask) !== (exp & mask)) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat, exp, mask);
	endtask

	// Counts pclk edges until busy drops
	task automatic wait_idle();
		#1;
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			@(posedge pclk);
			#1;
			n++;
		end
	endtask

	task automatic do_reset(input logic [7:0] hi, input logic [7:0] lo);
		@(posedge pclk);
		presetn <= 1'b0;
		vec_hi <= hi;
		vec_lo <= lo;
		repeat (3) @(posedge pclk);
		chk(32'(busy), 32'h0000_0000, ALL);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd_chk(ADDR_PSW, 32'(PSW_RESET), 32'h0000_0004);
		rd_chk(ADDR_PC, {16'h0000, hi, lo}, ALL);
		rd_chk(ADDR_STAT, 32'h0000_0002, 32'h0000_0002);
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		vec_hi = 8'hA5;
		vec_lo = 8'h3C;
		fail_count = 0;
		n_tests = 0;
		cyc_cnt = 0;
		do_reset(8'hA5, 8'h3C);
		foreach (rows[i]) begin
			apb(1'b1, ADDR_OPA, {24'h00_0000, rows[i].a});
			apb(1'b1, ADDR_OPB, {24'h00_0000, rows[i].b});
			apb(1'b1, ADDR_PSW, {24'h00_0000, rows[i].psw});
			apb(1'b1, ADDR_CMD, {28'h000_0000, rows[i].op});
			wait_idle();
			if (rows[i].cyc > 0) chk(32'(n), 32'(rows[i].cyc), ALL);
			rd_chk(ADDR_RES, 32'(rows[i].res), 32'(rows[i].rm));
			rd_chk(ADDR_PSW, 32'(rows[i].pe), 32'(rows[i].pm));
		end
		@(posedge pclk);
		#1;
		ph = cpu_clk;
		@(posedge pclk);
		#1;
		chk(32'(cpu_clk), 32'(!ph), ALL);
		apb(1'b1, ADDR_IRQ, 32'h0000_005A);
		apb(1'b1, ADDR_CMD, 32'(OP_NOP));
		wait_idle();
		rd_chk(ADDR_IRQ, 32'h0000_005A, 32'h0000_00FF);
		apb(1'b1, ADDR_IRQ, 32'h0000_00A5);
		rd_chk(ADDR_IRQ, 32'h0000_005A, 32'h0000_00FF);
		apb(1'b1, ADDR_CMD, 32'(OP_NOP));
		wait_idle();
		rd_chk(ADDR_IRQ, 32'h0000_00A5, 32'h0000_00FF);
		// Operand write during a multiply is stalled, so the product uses old operands
		apb(1'b1, ADDR_OPA, 32'h0000_0003);
		apb(1'b1, ADDR_OPB, 32'h0000_0005);
		apb(1'b1, ADDR_PSW, 32'h0000_00C3);
		apb(1'b1, ADDR_CMD, 32'(OP_MUL));
		apb(1'b1, ADDR_OPA, 32'h0000_0007);
		#1;
		chk(32'(busy), 32'h0000_0000, ALL);
		rd_chk(ADDR_RES, 32'h0000_000F, 32'h0000_FFFF);
		rd_chk(ADDR_OPA, 32'h0000_0007, 32'h0000_00FF);
		rd_chk(ADDR_PSW, 32'h0000_00C3, 32'h0000_00FF);
		apb(1'b1, ADDR_RES, 32'h0000_FFFF);
		rd_chk(ADDR_RES, 32'h0000_000F, 32'h0000_FFFF);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk(32'(rerr), 32'h0000_0001, ALL);
		// Reset in the middle of a divide
		apb(1'b1, ADDR_CMD, 32'(OP_DIV));
		do_reset(8'h12, 8'h80);
		end_of_test();
	end
endmodule
